/* File: quad_ddr_regs.vh */
// constants for the quad double-rate read and sector unlock command block
`ifndef QUAD_DDR_REGS_VH
`define QUAD_DDR_REGS_VH

`define QD_OP_READ        8'hed
`define QD_OP_UNLOCK      8'h26
`define QD_OP_RELOCK      8'h24
`define QD_MODE_CONT      4'ha
`define QD_DUMMY_DEFAULT  4'h3
`define QD_SPI_CMD_EDGES  6'h08
`define QD_QPI_CMD_EDGES  6'h02
`define QD_ADDR_EDGES     6'h06
`define QD_UADDR_SPI      6'h18
`define QD_UADDR_QPI      6'h06
`define QD_SECTOR_LSB     12
`define QD_SECTOR_W       12
`define QD_ARRAY_LAST     24'hffffff

`endif

/* File: qddr_pair_buffer.v */
// two-entry valid/ready buffer between the array read port and the output shifter
`timescale 1ns/1ps
module qddr_pair_buffer #(
   parameter WIDTH = 8,
   parameter DEPTH = 2,
   parameter IDX_W = 1
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             flush,
   input  wire             inValid,
   input  wire [WIDTH-1:0] inData,
   output reg              inReady_r,
   output wire             outValid,
   output wire [WIDTH-1:0] outData,
   input  wire             outReady
);
   localparam [IDX_W:0] DEPTH_C = DEPTH[IDX_W:0];
   localparam [IDX_W:0] LAST_C  = DEPTH_C - 1'b1;

   reg  [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg  [IDX_W-1:0] wrIdx_r;
   reg  [IDX_W-1:0] rdIdx_r;
   reg  [IDX_W:0]   count_r;
   reg  [IDX_W:0]   count_nxt;
   wire             push;
   wire             pop;

   assign outValid = (count_r != {(IDX_W+1){1'b0}});
   assign outData  = mem_r[rdIdx_r];
   assign push     = inValid & inReady_r & ~flush;
   assign pop      = outReady & outValid & ~flush;

   always @* begin
      count_nxt = count_r;
      if (push & ~pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop & ~push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem_r[wrIdx_r] <= inData;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrIdx_r   <= {IDX_W{1'b0}};
         rdIdx_r   <= {IDX_W{1'b0}};
         count_r   <= {(IDX_W+1){1'b0}};
         inReady_r <= 1'b0;
      end else if (flush) begin
         wrIdx_r   <= {IDX_W{1'b0}};
         rdIdx_r   <= {IDX_W{1'b0}};
         count_r   <= {(IDX_W+1){1'b0}};
         inReady_r <= 1'b1;
      end else begin
         if (push) begin
            wrIdx_r <= ({1'b0, wrIdx_r} == LAST_C) ? {IDX_W{1'b0}} : wrIdx_r + 1'b1;
         end
         if (pop) begin
            rdIdx_r <= ({1'b0, rdIdx_r} == LAST_C) ? {IDX_W{1'b0}} : rdIdx_r + 1'b1;
         end
         count_r   <= count_nxt;
         inReady_r <= (count_nxt < DEPTH_C);
      end
   end
endmodule // qddr_pair_buffer

/* File: quad_ddr_flash_cmd.v */
// serial flash command logic: quad double-rate read, continuous read, sector unlock and relock
`timescale 1ns/1ps
`include "quad_ddr_regs.vh"
module quad_ddr_flash_cmd #(
   parameter [23:0] ARRAY_LAST = `QD_ARRAY_LAST
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        csN,
   input  wire        sclk,
   input  wire [3:0]  ioIn,
   output reg  [3:0]  ioOut_r,
   output reg  [3:0]  ioOeN_r,
   input  wire        fourLineMode,
   input  wire        quadEnable,
   input  wire        writeInProgress,
   input  wire [3:0]  blockProtect,
   input  wire [3:0]  dummyCfg,
   output reg         rdReq_r,
   output reg  [23:0] rdAddr_r,
   input  wire        rdValid,
   input  wire [7:0]  rdData,
   output wire        rdReady,
   output reg         contRead_r,
   output reg         unlockValid_r,
   output reg  [11:0] unlockSector_r,
   input  wire [23:0] chkAddr,
   output reg         chkWritable_r,
   output reg         cmdRejected_r
);
   localparam [7:0] ST_IDLE   = 8'h01;
   localparam [7:0] ST_CMD    = 8'h02;
   localparam [7:0] ST_ADDR   = 8'h04;
   localparam [7:0] ST_DUMMY  = 8'h08;
   localparam [7:0] ST_DATA   = 8'h10;
   localparam [7:0] ST_UADDR  = 8'h20;
   localparam [7:0] ST_RELOCK = 8'h40;
   localparam [7:0] ST_IGNORE = 8'h80;

   // pin synchronisers
   reg        csM_r;
   reg        csS_r;
   reg        sckM_r;
   reg        sckS_r;
   reg        sckD_r;
   reg  [3:0] ioM_r;
   reg  [3:0] ioS_r;

   reg  [7:0]  state_r;
   reg  [5:0]  cnt_r;
   reg  [7:0]  cmdSh_r;
   reg  [23:0] addrSh_r;
   reg  [7:0]  outByte_r;
   reg         uaDone_r;
   reg         fetchEn_r;
   reg         pending_r;
   reg         drop_r;

   wire        sckRise;
   wire        sckFall;
   wire        edgeAny;
   wire [3:0]  dummyClk;
   wire [5:0]  dummyEdges;
   wire [7:0]  cmdNext;
   wire [5:0]  cmdEdges;
   wire [23:0] addrNext;
   wire [23:0] uaNext;
   wire [5:0]  uaEdges;
   wire        addrTake;
   wire        addrLast;
   wire        lastDummy;
   wire        popByte;
   wire        pushByte;
   wire        bufInReady;
   wire        bufOutValid;
   wire [7:0]  bufData;
   wire        readRefused;

   assign sckRise = sckS_r & ~sckD_r & ~csS_r;
   assign sckFall = ~sckS_r & sckD_r & ~csS_r;
   assign edgeAny = sckRise | sckFall;

   // a zero setting selects the default dummy count
   assign dummyClk   = (dummyCfg == 4'h0) ? `QD_DUMMY_DEFAULT : dummyCfg;
   assign dummyEdges = {1'b0, dummyClk, 1'b0};

   // opcode shift: one bit on line 0, or a nibble in four-line mode
   assign cmdNext  = fourLineMode ? {cmdSh_r[3:0], ioS_r} : {cmdSh_r[6:0], ioS_r[0]};
   assign cmdEdges = fourLineMode ? `QD_QPI_CMD_EDGES : `QD_SPI_CMD_EDGES;

   // read address: a nibble on every edge, first nibble on a rising edge
   assign addrNext = {addrSh_r[19:0], ioS_r};
   assign addrTake = edgeAny & (sckRise | (cnt_r != 6'h00));
   assign addrLast = (state_r == ST_ADDR) & addrTake & (cnt_r == `QD_ADDR_EDGES - 6'h01);

   // unlock address is single-rate like the opcode
   assign uaNext  = fourLineMode ? {addrSh_r[19:0], ioS_r} : {addrSh_r[22:0], ioS_r[0]};
   assign uaEdges = fourLineMode ? `QD_UADDR_QPI : `QD_UADDR_SPI;

   assign lastDummy = sckFall & (cnt_r == dummyEdges - 6'h01);
   assign popByte   = ((state_r == ST_DUMMY) & lastDummy) | ((state_r == ST_DATA) & sckFall);
   assign pushByte  = rdValid & pending_r & ~drop_r & fetchEn_r;

   // busy array, or single-line mode without quad enable
   assign readRefused = writeInProgress | (~fourLineMode & ~quadEnable);

   qddr_pair_buffer #(
      .WIDTH (8),
      .DEPTH (2),
      .IDX_W (1)
   ) u_buf (
      .clk       (clk),
      .rst       (rst),
      .flush     (csS_r),
      .inValid   (pushByte),
      .inData    (rdData),
      .inReady_r (bufInReady),
      .outValid  (bufOutValid),
      .outData   (bufData),
      .outReady  (popByte)
   );

   assign rdReady = bufInReady;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         csM_r  <= 1'b1;
         csS_r  <= 1'b1;
         sckM_r <= 1'b0;
         sckS_r <= 1'b0;
         sckD_r <= 1'b0;
         ioM_r  <= 4'h0;
         ioS_r  <= 4'h0;
      end else begin
         csM_r  <= csN;
         csS_r  <= csM_r;
         sckM_r <= sclk;
         sckS_r <= sckM_r;
         sckD_r <= sckS_r;
         ioM_r  <= ioIn;
         ioS_r  <= ioM_r;
      end
   end

   // array fetch: one request in flight, only while the buffer has room
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         fetchEn_r <= 1'b0;
         pending_r <= 1'b0;
         drop_r    <= 1'b0;
         rdReq_r   <= 1'b0;
         rdAddr_r  <= 24'h000000;
      end else begin
         rdReq_r <= 1'b0;
         if (rdValid) begin
            pending_r <= 1'b0;
            drop_r    <= 1'b0;
         end
         if (csS_r) begin
            fetchEn_r <= 1'b0;
            if (pending_r & ~rdValid) begin
               drop_r <= 1'b1;
            end
         end else if (addrLast) begin
            fetchEn_r <= 1'b1;
            rdAddr_r  <= addrNext;
         end else if (fetchEn_r & ~pending_r & ~rdReq_r & bufInReady) begin
            rdReq_r   <= 1'b1;
            pending_r <= 1'b1;
         end
         if (rdReq_r) begin
            rdAddr_r <= (rdAddr_r == ARRAY_LAST) ? 24'h000000 : rdAddr_r + 24'h000001;
         end
      end
   end

   // command state machine
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r        <= ST_IDLE;
         cnt_r          <= 6'h00;
         cmdSh_r        <= 8'h00;
         addrSh_r       <= 24'h000000;
         outByte_r      <= 8'h00;
         uaDone_r       <= 1'b0;
         ioOut_r        <= 4'h0;
         ioOeN_r        <= 4'hf;
         contRead_r     <= 1'b0;
         unlockValid_r  <= 1'b0;
         unlockSector_r <= 12'h000;
         cmdRejected_r  <= 1'b0;
      end else begin
         cmdRejected_r <= 1'b0;
         if (csS_r) begin
            // unlock and relock take effect when select rises
            if ((state_r == ST_UADDR) && uaDone_r && !unlockValid_r && (blockProtect != 4'h0)) begin
               unlockValid_r  <= 1'b1;
               unlockSector_r <= addrSh_r[`QD_SECTOR_LSB + `QD_SECTOR_W - 1:`QD_SECTOR_LSB];
            end
            if (state_r == ST_RELOCK) begin
               unlockValid_r <= 1'b0;
            end
            state_r  <= ST_IDLE;
            cnt_r    <= 6'h00;
            uaDone_r <= 1'b0;
            ioOeN_r  <= 4'hf;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  cnt_r <= 6'h00;
                  if (contRead_r) begin
                     if (writeInProgress) begin
                        state_r       <= ST_IGNORE;
                        cmdRejected_r <= 1'b1;
                     end else begin
                        state_r <= ST_ADDR;
                     end
                  end else begin
                     state_r <= ST_CMD;
                  end
               end
               ST_CMD: begin
                  if (sckRise) begin
                     cmdSh_r <= cmdNext;
                     cnt_r   <= cnt_r + 6'h01;
                     if (cnt_r == cmdEdges - 6'h01) begin
                        cnt_r <= 6'h00;
                        case (cmdNext)
                           `QD_OP_READ: begin
                              if (readRefused) begin
                                 state_r       <= ST_IGNORE;
                                 cmdRejected_r <= 1'b1;
                              end else begin
                                 state_r <= ST_ADDR;
                              end
                           end
                           `QD_OP_UNLOCK: begin
                              state_r <= ST_UADDR;
                           end
                           `QD_OP_RELOCK: begin
                              state_r <= ST_RELOCK;
                           end
                           default: begin
                              state_r <= ST_IGNORE;
                           end
                        endcase
                     end
                  end
               end
               ST_ADDR: begin
                  if (addrTake) begin
                     addrSh_r <= addrNext;
                     cnt_r    <= cnt_r + 6'h01;
                     if (addrLast) begin
                        cnt_r   <= 6'h00;
                        state_r <= ST_DUMMY;
                     end
                  end
               end
               ST_DUMMY: begin
                  if (edgeAny) begin
                     cnt_r <= cnt_r + 6'h01;
                     if (sckRise && (cnt_r == 6'h00)) begin
                        // high mode nibble decides the next read; low nibble ignored
                        contRead_r <= (ioS_r == `QD_MODE_CONT);
                     end
                     if (lastDummy) begin
                        cnt_r     <= 6'h00;
                        state_r   <= ST_DATA;
                        outByte_r <= bufData;
                        ioOut_r   <= bufData[7:4];
                        ioOeN_r   <= 4'h0;
                     end
                  end
               end
               ST_DATA: begin
                  // high nibble stands for the rising edge, low for the falling
                  if (sckRise) begin
                     ioOut_r <= outByte_r[3:0];
                  end
                  if (sckFall) begin
                     outByte_r <= bufData;
                     ioOut_r   <= bufData[7:4];
                  end
               end
               ST_UADDR: begin
                  if (sckRise && !uaDone_r) begin
                     addrSh_r <= uaNext;
                     cnt_r    <= cnt_r + 6'h01;
                     if (cnt_r == uaEdges - 6'h01) begin
                        uaDone_r <= 1'b1;
                     end
                  end
               end
               ST_RELOCK: begin
                  state_r <= ST_RELOCK;
               end
               ST_IGNORE: begin
                  state_r <= ST_IGNORE;
               end
               default: begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // write permission query: protection off (blockProtect zero), or inside the one unlocked sector
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         chkWritable_r <= 1'b0;
      end else begin
         chkWritable_r <= (blockProtect == 4'h0) |
                          (unlockValid_r &
                           (chkAddr[`QD_SECTOR_LSB + `QD_SECTOR_W - 1:`QD_SECTOR_LSB] == unlockSector_r));
      end
   end
endmodule // quad_ddr_flash_cmd

/* File: quad_ddr_flash_cmd_sva.sv */
// port checks for the quad read and sector unlock command block
`timescale 1ns/1ps
module quad_ddr_flash_cmd_sva #(
   parameter [23:0] ARRAY_LAST = 24'hffffff
) (
   input wire        clk,
   input wire        rst,
   input wire        csN,
   input wire [3:0]  ioOeN_r,
   input wire        fourLineMode,
   input wire        quadEnable,
   input wire        writeInProgress,
   input wire [3:0]  blockProtect,
   input wire        rdReq_r,
   input wire [23:0] rdAddr_r,
   input wire        unlockValid_r,
   input wire [11:0] unlockSector_r,
   input wire [23:0] chkAddr,
   input wire        chkWritable_r,
   input wire        cmdRejected_r
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   release_drive_a: assert property (
      $rose(csN) |-> ##[1:6] ioOeN_r == 4'hf) else $error("lines driven after deselect");
   idle_float_a: assert property (
      csN [*6] |-> ioOeN_r == 4'hf) else $error("lines driven while deselected");
   reject_pulse_a: assert property (
      cmdRejected_r |=> !cmdRejected_r) else $error("refusal pulse too long");
   reject_cause_a: assert property (
      cmdRejected_r |-> writeInProgress || (!fourLineMode && !quadEnable)) else $error("refusal without cause");
   reject_quiet_a: assert property (
      cmdRejected_r |-> (ioOeN_r == 4'hf) [*8]) else $error("refused read drives lines");
   addr_step_a: assert property (
      rdReq_r |=> rdAddr_r == ($past(rdAddr_r) == ARRAY_LAST ? 24'h0 : $past(rdAddr_r) + 24'h1))
      else $error("read address did not step");
   unlock_cause_a: assert property (
      $rose(unlockValid_r) |-> csN && blockProtect != 4'h0) else $error("unlock without protection");
   sector_hold_a: assert property (
      unlockValid_r && $past(unlockValid_r) |-> $stable(unlockSector_r)) else $error("unlocked sector moved");
   write_guard_a: assert property (
      !$past(rst) |-> chkWritable_r == ($past(blockProtect) == 4'h0 || $past(unlockValid_r)
      && $past(chkAddr) >> 12 == {12'h0, $past(unlockSector_r)})) else $error("write permission wrong");
   cover property (cmdRejected_r);
   cover property (csN == 1'b0 && ioOeN_r == 4'h0);
   cover property ($rose(unlockValid_r));
endmodule // quad_ddr_flash_cmd_sva

bind quad_ddr_flash_cmd quad_ddr_flash_cmd_sva #(.ARRAY_LAST(ARRAY_LAST)) u_quad_ddr_flash_cmd_sva (
   .clk(clk), .rst(rst), .csN(csN), .ioOeN_r(ioOeN_r), .fourLineMode(fourLineMode),
   .quadEnable(quadEnable), .writeInProgress(writeInProgress), .blockProtect(blockProtect),
   .rdReq_r(rdReq_r), .rdAddr_r(rdAddr_r), .unlockValid_r(unlockValid_r),
   .unlockSector_r(unlockSector_r), .chkAddr(chkAddr), .chkWritable_r(chkWritable_r),
   .cmdRejected_r(cmdRejected_r));

/* File: qspi_host.sv */
// host controller model driving select, serial clock and the four data lines
`timescale 1ns/1ps
module qspi_host (
   input  wire       clk,
   output reg        csN,
   output reg        sclk,
   output wire [3:0] ioIn,
   input  wire [3:0] ioOut_r,
   input  wire [3:0] ioOeN_r
);
   reg [3:0] hostIo;
   reg       hostDrive;
   integer   i;
   // undriven lines show the inverse of the host's last value
   assign ioIn = (~ioOeN_r & ioOut_r) | (ioOeN_r & (hostDrive ? hostIo : ~hostIo));
   initial begin
      csN = 1'b1;
      sclk = 1'b0;
      hostIo = 4'h0;
      hostDrive = 1'b0;
   end
   task edgeOut(input [3:0] n);
      begin
         repeat (2) @(posedge clk);
         hostIo <= n;
         hostDrive <= 1'b1;
         repeat (2) @(posedge clk);
         sclk <= ~sclk;
      end
   endtask
   task edgeIn(output [3:0] n);
      begin
         repeat (4) @(posedge clk);
         n = ioIn;
         sclk <= ~sclk;
      end
   endtask
   task startFrame;
      begin
         @(posedge clk);
         csN <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask
   // ddr=0 holds each unit over a rise and a fall
   task shiftOut(input [23:0] v, input integer nBits, input four, input ddr);
      reg [3:0] nib;
      begin
         for (i = 0; i < (four ? nBits / 4 : nBits); i = i + 1) begin
            nib = four ? v[nBits - 1 - 4 * i -: 4] : {3'b000, v[nBits - 1 - i]};
            edgeOut(nib);
            if (!ddr)
               edgeOut(nib);
         end
      end
   endtask
   task dummy(input [3:0] mode, input integer n);
      reg [3:0] junk;
      begin
         edgeOut(mode);
         repeat (2) @(posedge clk);
         hostDrive <= 1'b0;
         for (i = 1; i < 2 * n; i = i + 1)
            edgeIn(junk);
      end
   endtask
   task readByte(output [7:0] b);
      reg [3:0] hi;
      reg [3:0] lo;
      begin
         edgeIn(hi);
         edgeIn(lo);
         b = {hi, lo};
      end
   endtask
   task endFrame;
      begin
         @(posedge clk);
         csN <= 1'b1;
         hostDrive <= 1'b0;
         repeat (6) @(posedge clk);
      end
   endtask
endmodule // qspi_host

/* File: tb_quad_ddr_flash_cmd.sv */
// self-checking bench for the quad read and sector unlock command block
`timescale 1ns/1ps
module tb_quad_ddr_flash_cmd;
   localparam [23:0] LAST = 24'h0000ff;
   reg         clk, rst, fourLineMode, quadEnable, writeInProgress, rdValid, v1, v2;
   reg  [3:0]  blockProtect, dummyCfg;
   reg  [7:0]  rdData;
   reg  [23:0] chkAddr, a1, a2;
   wire        csN, sclk, rdReq_r, rdReady, contRead_r, unlockValid_r, chkWritable_r, cmdRejected_r;
   wire [3:0]  ioIn, ioOut_r, ioOeN_r;
   wire [23:0] rdAddr_r;
   wire [11:0] unlockSector_r;
   integer     n_fail, comparisons, cycles, rejects;
   quad_ddr_flash_cmd #(.ARRAY_LAST(LAST)) u_quad_ddr_flash_cmd (
      .clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut_r(ioOut_r), .ioOeN_r(ioOeN_r),
      .fourLineMode(fourLineMode), .quadEnable(quadEnable), .writeInProgress(writeInProgress),
      .blockProtect(blockProtect), .dummyCfg(dummyCfg), .rdReq_r(rdReq_r), .rdAddr_r(rdAddr_r),
      .rdValid(rdValid), .rdData(rdData), .rdReady(rdReady), .contRead_r(contRead_r),
      .unlockValid_r(unlockValid_r), .unlockSector_r(unlockSector_r), .chkAddr(chkAddr),
      .chkWritable_r(chkWritable_r), .cmdRejected_r(cmdRejected_r));
   qspi_host u_qspi_host (
      .clk(clk), .csN(csN), .sclk(sclk), .ioIn(ioIn), .ioOut_r(ioOut_r), .ioOeN_r(ioOeN_r));
   always #10 clk = ~clk;
   // array answers three cycles after each request; the middle address byte is folded in so a missed wrap shows
   always @(posedge clk) begin
      v1 <= rdReq_r;
      a1 <= rdAddr_r;
      v2 <= v1;
      a2 <= a1;
      rdValid <= v2;
      rdData <= a2[7:0] ^ a2[15:8] ^ 8'h3c;
      rejects <= rejects + (cmdRejected_r === 1'b1 ? 1 : 0);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         conclude;
      end
   end
   task check(input string what, input [23:0] seen, input [23:0] exp);
      begin
         comparisons = comparisons + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, n_fail);
         if (n_fail == 0 && comparisons > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   task setMode(input four, input qe, input write_in_progress_flag, input [3:0] dcfg, input [3:0] bp);
      begin
         @(posedge clk);
         fourLineMode <= four;
         quadEnable <= qe;
         writeInProgress <= write_in_progress_flag;
         dummyCfg <= dcfg;
         blockProtect <= bp;
      end
   endtask
   task readFrame(input cont, input [23:0] a, input [3:0] mode, input integer n);
      integer k;
      reg [7:0] b;
      begin
         u_qspi_host.startFrame;
         if (!cont)
            u_qspi_host.shiftOut(24'hed, 8, fourLineMode, 1'b0);
         u_qspi_host.shiftOut(a, 24, 1'b1, 1'b1);
         u_qspi_host.dummy(mode, dummyCfg == 4'h0 ? 3 : dummyCfg);
         check("buffer room", {23'h0, rdReady}, 24'h0);
         for (k = 0; k < n; k = k + 1) begin
            u_qspi_host.readByte(b);
            check("read byte", {16'h0, b}, {16'h0, a[7:0] ^ a[15:8] ^ 8'h3c});
            a = (a == LAST) ? 24'h0 : a + 24'h1;
         end
         u_qspi_host.endFrame;
      end
   endtask
   task cmdFrame(input [7:0] op, input [23:0] a, input integer nBits);
      begin
         u_qspi_host.startFrame;
         u_qspi_host.shiftOut({16'h0, op}, 8, fourLineMode, 1'b0);
         if (nBits > 0)
            u_qspi_host.shiftOut(a, nBits, fourLineMode, 1'b0);
         u_qspi_host.endFrame;
      end
   endtask
   task probe(input [23:0] a, input exp);
      begin
         @(posedge clk);
         chkAddr <= a;
         repeat (2) @(posedge clk);
         check("writable", {23'h0, chkWritable_r}, {23'h0, exp});
      end
   endtask
   task singleLineRead;
      begin
         setMode(1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
         readFrame(1'b0, 24'h0000fe, 4'h0, 4);
         check("continuous", {23'h0, contRead_r}, 24'h0);
         check("buffer room", {23'h0, rdReady}, 24'h1);
      end
   endtask
   task continuousRead;
      begin
         setMode(1'b1, 1'b0, 1'b0, 4'h2, 4'h0);
         readFrame(1'b0, 24'h000010, 4'ha, 3);
         check("continuous", {23'h0, contRead_r}, 24'h1);
         rejectFrame(1'b1, 1'b0, 1'b1, 1'b1);
         setMode(1'b1, 1'b0, 1'b0, 4'h2, 4'h0);
         readFrame(1'b1, 24'h000080, 4'h5, 2);
         check("continuous", {23'h0, contRead_r}, 24'h0);
         readFrame(1'b0, 24'h000033, 4'h0, 1);
      end
   endtask
   task rejectFrame(input four, input qe, input write_in_progress_flag, input cont);
      integer r;
      begin
         setMode(four, qe, write_in_progress_flag, 4'h0, 4'h0);
         r = rejects;
         u_qspi_host.startFrame;
         if (!cont)
            u_qspi_host.shiftOut(24'hed, 8, four, 1'b0);
         u_qspi_host.shiftOut(24'h000020, 24, 1'b1, 1'b1);
         u_qspi_host.dummy(4'h0, 3);
         repeat (8) @(posedge clk);
         check("drive enable", {20'h0, ioOeN_r}, 24'hf);
         u_qspi_host.endFrame;
         check("refusals", rejects - r, 24'h1);
      end
   endtask
   task unlockRelock;
      begin
         setMode(1'b0, 1'b1, 1'b0, 4'h0, 4'h0);
         cmdFrame(8'h26, 24'h123456, 24);
         check("unlocked", {23'h0, unlockValid_r}, 24'h0);
         setMode(1'b0, 1'b1, 1'b0, 4'h0, 4'h1);
         cmdFrame(8'h26, 24'h123456, 24);
         check("unlocked", {23'h0, unlockValid_r}, 24'h1);
         check("sector", {12'h0, unlockSector_r}, 24'h123);
         probe(24'h123fff, 1'b1);
         probe(24'h124000, 1'b0);
         setMode(1'b1, 1'b1, 1'b0, 4'h0, 4'h1);
         cmdFrame(8'h26, 24'h777000, 24);
         check("sector", {12'h0, unlockSector_r}, 24'h123);
         cmdFrame(8'h24, 24'h0, 0);
         check("unlocked", {23'h0, unlockValid_r}, 24'h0);
         probe(24'h123abc, 1'b0);
         cmdFrame(8'h26, 24'h777000, 24);
         check("sector", {12'h0, unlockSector_r}, 24'h777);
      end
   endtask
   initial begin
      {clk, fourLineMode, quadEnable, writeInProgress, rdValid, v1, v2} = 7'h0;
      {blockProtect, dummyCfg, rdData, chkAddr, a1, a2} = 88'h0;
      {n_fail, comparisons, cycles, rejects} = 128'h0;
      rst = 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      singleLineRead;
      continuousRead;
      rejectFrame(1'b1, 1'b1, 1'b1, 1'b0);
      rejectFrame(1'b0, 1'b0, 1'b0, 1'b0);
      unlockRelock;
      conclude;
   end
endmodule // tb_quad_ddr_flash_cmd
